// ### hdl/esled_consts.svh
// Purpose: constants for the ethernet status led driver
// Assumes: core_clk at 50 MHz
// Notes: all indicator outputs are active low
//
// Overview of operation
// - The link indicator is driven low and held steady while a 10 or 100 Mbit link is up and no frames move.
// - While the link is up and frames move in either direction the link indicator flashes.
// - The speed indicator is low when the link runs at 100 Mbit/s and high otherwise.
// - The duplex indicator is low in full duplex and high in half duplex.
// - The collision indicator is low while a collision is present and high otherwise.
// - The receive indicator is low while receive activity is present and high otherwise.
// - The transmit indicator is low while transmit activity is present and high otherwise.
`ifndef ESLED_CONSTS_SVH
`define ESLED_CONSTS_SVH

// ============================================================
// timing
`define ESLED_CLK_HZ 50000000
`define ESLED_FLASH_HALF_MS 50
`define ESLED_FLASH_HALF_CYC ((`ESLED_CLK_HZ / 1000) * `ESLED_FLASH_HALF_MS)
`define ESLED_SYNC_STAGES 3

// ============================================================
// levels
`define ESLED_OFF 1'b1
`define ESLED_ON 1'b0

`endif

// ### hdl/esled_pkg.sv
// Purpose: types for the ethernet status led driver
// Assumes: nothing
// Notes: status fields are active high
package esled_pkg;
    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic full_duplex;
        logic collision;
        logic rx_active;
        logic tx_active;
    } esled_status_t;

    typedef enum logic [1:0] {
        ESLED_LINK_DOWN,
        ESLED_LINK_STEADY,
        ESLED_LINK_FLASH
    } esled_link_state_t;
endpackage : esled_pkg

// ### hdl/esled_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: asynchronous status input
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
module esled_sync #(
    parameter int WIDTH = 6
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    s1_reg[i] <= 1'b0;
                    s2_reg[i] <= 1'b0;
                    s3_reg[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    s1_reg[i] <= async_in[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    if (s2_reg[i] == s3_reg[i]) begin
                        sync_out[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate
endmodule : esled_sync

// ### hdl/esled_top.sv
// Purpose: drives six active-low status indicators from phy/mac status
// Assumes: status inputs arrive asynchronously; core_clk 50 MHz
// Notes: link indicator flashes during traffic while the link is up
`timescale 1ns/1ps
`include "esled_consts.svh"
module esled_top #(
    parameter int FLASH_HALF_CYC = `ESLED_FLASH_HALF_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire esled_pkg::esled_status_t status_in,
    output logic link_indicator_n,
    output logic speed_indicator_n,
    output logic duplex_indicator_n,
    output logic collision_indicator_n,
    output logic receive_activity_indicator_n,
    output logic transmit_activity_indicator_n
);
    // ============================================================
    // input synchronisation
    esled_pkg::esled_status_t st;
    esled_sync #(.WIDTH($bits(esled_pkg::esled_status_t))) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(status_in),
        .sync_out(st)
    );

    // ============================================================
    // flash rate divider
    logic [31:0] div_reg;
    logic [31:0] div_next;
    logic flash_tick;
    logic phase_reg;
    assign flash_tick = (div_reg == 32'(FLASH_HALF_CYC - 1));
    assign div_next = flash_tick ? 32'h0 : div_reg + 32'h1;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_reg <= 32'h0;
            phase_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            if (flash_tick) begin
                phase_reg <= ~phase_reg;
            end
        end
    end

    // ============================================================
    // link state
    esled_pkg::esled_link_state_t state_reg;
    esled_pkg::esled_link_state_t state_next;
    logic traffic;
    assign traffic = st.rx_active | st.tx_active;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            esled_pkg::ESLED_LINK_DOWN: begin
                if (st.link_up) begin
                    state_next = traffic ? esled_pkg::ESLED_LINK_FLASH
                                         : esled_pkg::ESLED_LINK_STEADY;
                end
            end
            esled_pkg::ESLED_LINK_STEADY: begin
                if (!st.link_up) begin
                    state_next = esled_pkg::ESLED_LINK_DOWN;
                end else if (traffic) begin
                    state_next = esled_pkg::ESLED_LINK_FLASH;
                end
            end
            esled_pkg::ESLED_LINK_FLASH: begin
                if (!st.link_up) begin
                    state_next = esled_pkg::ESLED_LINK_DOWN;
                end else if (!traffic) begin
                    state_next = esled_pkg::ESLED_LINK_STEADY;
                end
            end
            default: state_next = esled_pkg::ESLED_LINK_DOWN;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= esled_pkg::ESLED_LINK_DOWN;
        end else begin
            state_reg <= state_next;
        end
    end

    // ============================================================
    // indicator outputs
    logic link_next;
    // steady on, or on during flash phase 0
    assign link_next = (state_next == esled_pkg::ESLED_LINK_STEADY) ? `ESLED_ON :
                       (state_next == esled_pkg::ESLED_LINK_FLASH) ? phase_reg :
                       `ESLED_OFF;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            link_indicator_n <= `ESLED_OFF;
            speed_indicator_n <= `ESLED_OFF;
            duplex_indicator_n <= `ESLED_OFF;
            collision_indicator_n <= `ESLED_OFF;
            receive_activity_indicator_n <= `ESLED_OFF;
            transmit_activity_indicator_n <= `ESLED_OFF;
        end else begin
            link_indicator_n <= link_next;
            speed_indicator_n <= ~st.speed_100;
            duplex_indicator_n <= ~st.full_duplex;
            collision_indicator_n <= ~st.collision;
            receive_activity_indicator_n <= ~st.rx_active;
            transmit_activity_indicator_n <= ~st.tx_active;
        end
    end

    // ============================================================
    // checks: reset
    logic all_off;
    assign all_off = link_indicator_n & speed_indicator_n & duplex_indicator_n
                     & collision_indicator_n & receive_activity_indicator_n
                     & transmit_activity_indicator_n;

    chk_reset_all_off: assert property (@(posedge core_clk)
        rst |=> all_off)
        else $error("indicator active right after reset");

    chk_release_quiet: assert property (@(posedge core_clk)
        $fell(rst) |-> all_off ##1 all_off ##1 all_off)
        else $error("indicator active before synchronised input arrived");

    // ============================================================
    // checks: link state
    chk_state_legal: assert property (@(posedge core_clk) disable iff (rst)
        state_reg inside {esled_pkg::ESLED_LINK_DOWN, esled_pkg::ESLED_LINK_STEADY,
            esled_pkg::ESLED_LINK_FLASH})
        else $error("link state register holds an unused code");

    chk_state_down: assert property (@(posedge core_clk) disable iff (rst)
        !st.link_up |=> (state_reg == esled_pkg::ESLED_LINK_DOWN))
        else $error("link state not down without link");

    chk_state_steady: assert property (@(posedge core_clk) disable iff (rst)
        (st.link_up && !traffic) |=> (state_reg == esled_pkg::ESLED_LINK_STEADY))
        else $error("link state not steady on idle link");

    chk_state_flash: assert property (@(posedge core_clk) disable iff (rst)
        (st.link_up && traffic) |=> (state_reg == esled_pkg::ESLED_LINK_FLASH))
        else $error("link state not flashing during traffic");

    // ============================================================
    // checks: link indicator
    chk_link_steady_on: assert property (@(posedge core_clk) disable iff (rst)
        (st.link_up && !traffic) |=> !link_indicator_n)
        else $error("link indicator not steady low");

    chk_link_flash_phase: assert property (@(posedge core_clk) disable iff (rst)
        (st.link_up && traffic) |=> (link_indicator_n == $past(phase_reg)))
        else $error("link indicator not following flash phase");

    chk_link_down_off: assert property (@(posedge core_clk) disable iff (rst)
        !st.link_up |=> link_indicator_n)
        else $error("link indicator lit with link down");

    // ============================================================
    // checks: flash timing
    chk_div_range: assert property (@(posedge core_clk) disable iff (rst)
        div_reg < 32'(FLASH_HALF_CYC))
        else $error("flash divider beyond its period");

    chk_div_wrap: assert property (@(posedge core_clk) disable iff (rst)
        flash_tick |=> (div_reg == 32'h0))
        else $error("flash divider did not wrap");

    chk_div_count: assert property (@(posedge core_clk) disable iff (rst)
        !flash_tick |=> (div_reg == $past(div_reg) + 32'h1))
        else $error("flash divider did not count");

    chk_phase_toggle: assert property (@(posedge core_clk) disable iff (rst)
        flash_tick |=> (phase_reg != $past(phase_reg)))
        else $error("flash phase did not toggle");

    chk_phase_hold: assert property (@(posedge core_clk) disable iff (rst)
        !flash_tick |=> (phase_reg == $past(phase_reg)))
        else $error("flash phase changed between ticks");

    // ============================================================
    // checks: status indicators
    chk_speed_follow: assert property (@(posedge core_clk) disable iff (rst)
        st.speed_100 |=> !speed_indicator_n)
        else $error("speed indicator wrong");

    chk_speed_level: assert property (@(posedge core_clk) disable iff (rst)
        ##1 (speed_indicator_n == !$past(st.speed_100)))
        else $error("speed indicator not following speed");

    chk_duplex_follow: assert property (@(posedge core_clk) disable iff (rst)
        !st.full_duplex |=> duplex_indicator_n)
        else $error("duplex indicator wrong");

    chk_duplex_level: assert property (@(posedge core_clk) disable iff (rst)
        ##1 (duplex_indicator_n == !$past(st.full_duplex)))
        else $error("duplex indicator not following duplex mode");

    chk_coll_follow: assert property (@(posedge core_clk) disable iff (rst)
        st.collision |=> !collision_indicator_n)
        else $error("collision indicator wrong");

    chk_coll_level: assert property (@(posedge core_clk) disable iff (rst)
        ##1 (collision_indicator_n == !$past(st.collision)))
        else $error("collision indicator not following collision");

    chk_rx_follow: assert property (@(posedge core_clk) disable iff (rst)
        $rose(st.rx_active) |=> !receive_activity_indicator_n)
        else $error("receive indicator wrong");

    chk_rx_level: assert property (@(posedge core_clk) disable iff (rst)
        ##1 (receive_activity_indicator_n == !$past(st.rx_active)))
        else $error("receive indicator not following receive activity");

    chk_tx_follow: assert property (@(posedge core_clk) disable iff (rst)
        $fell(st.tx_active) |=> transmit_activity_indicator_n)
        else $error("transmit indicator wrong");

    chk_tx_level: assert property (@(posedge core_clk) disable iff (rst)
        ##1 (transmit_activity_indicator_n == !$past(st.tx_active)))
        else $error("transmit indicator not following transmit activity");
endmodule : esled_top

// ### testbench/esled_led_model.sv
// Purpose: board lamps driven by the active-low indicator lines
// Assumes: lamp lit while its line is low
// Notes: counts link lamp changes to judge flashing
`timescale 1ns/1ps
module esled_led_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [5:0] drive_n,
    output logic [5:0] lit,
    output int link_changes
);
    logic last_link_reg;
    assign lit = ~drive_n;
    always_ff @(posedge core_clk) begin
        last_link_reg <= drive_n[5];
        if (rst) begin
            link_changes <= 0;
        end else if (drive_n[5] !== last_link_reg) begin
            link_changes <= link_changes + 1;
        end
    end
endmodule : esled_led_model

// ### testbench/ethernet_status_led_driver_tb.sv
// Purpose: self-checking bench for the status indicator driver
// Assumes: five-edge input to output latency, flash half period of 8
// Notes: drive_n bit order follows the status struct
`timescale 1ns/1ps
module ethernet_status_led_driver_tb;
    localparam int HALF = 8;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    esled_pkg::esled_status_t status_in = '0;
    wire logic [5:0] drive_n;
    logic [5:0] lit;
    int link_changes;
    int n_errors = 0;
    int check_count = 0;
    always #10 core_clk = ~core_clk;
    esled_top #(.FLASH_HALF_CYC(HALF)) DUT (.core_clk(core_clk), .rst(rst),
        .status_in(status_in), .link_indicator_n(drive_n[5]), .speed_indicator_n(drive_n[4]),
        .duplex_indicator_n(drive_n[3]), .collision_indicator_n(drive_n[2]),
        .receive_activity_indicator_n(drive_n[1]), .transmit_activity_indicator_n(drive_n[0]));
    esled_led_model lamps (.core_clk(core_clk), .rst(rst), .drive_n(drive_n), .lit(lit),
        .link_changes(link_changes));
    // ============================================================
    // helpers
    task check(input string what, input logic seen, input logic exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    task wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc
    task set(input logic [5:0] v);
        @(posedge core_clk);
        status_in <= v;
    endtask : set
    task tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // ============================================================
    // scenarios
    task t_all_off();
        for (int k = 0; k < 6; k++) check("off after reset", drive_n[k], 1'b1);
    endtask : t_all_off
    task t_pattern(input logic [5:0] v);
        set(v);
        wait_cyc(7);
        check("link", drive_n[5], 1'b1);
        check("speed", drive_n[4], ~v[4]);
        check("duplex", drive_n[3], ~v[3]);
        check("collision", drive_n[2], ~v[2]);
        check("receive", drive_n[1], ~v[1]);
        check("transmit", drive_n[0], ~v[0]);
    endtask : t_pattern
    task t_watch(input logic [5:0] v, input int lo, input int hi);
        int c0;
        set(v);
        wait_cyc(7);
        c0 = link_changes;
        wait_cyc(4 * HALF);
        check("link changes", (link_changes - c0 >= lo) && (link_changes - c0 <= hi), 1'b1);
    endtask : t_watch
    task t_link();
        t_watch(6'h20, 0, 0);
        check("link steady", drive_n[5], 1'b0);
        t_watch(6'h22, 3, 5);
        t_watch(6'h21, 3, 5);
        t_watch(6'h03, 0, 0);
        check("link down", drive_n[5], 1'b1);
    endtask : t_link
    task t_mid_reset();
        set(6'h3F);
        wait_cyc(7);
        @(posedge core_clk);
        rst <= 1'b1;
        wait_cyc(2);
        t_all_off();
        @(posedge core_clk);
        rst <= 1'b0;
        wait_cyc(1);
        check("link after release", drive_n[5], 1'b1);
        check("speed after release", drive_n[4], 1'b1);
        wait_cyc(7);
        for (int k = 0; k < 5; k++) check("lamp lit again", lit[k], 1'b1);
    endtask : t_mid_reset
    // ============================================================
    // main sequence and watchdog
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        wait_cyc(1);
        t_all_off();
        t_pattern(6'h15);
        t_pattern(6'h0A);
        t_link();
        t_mid_reset();
        tally_and_finish();
    end
    initial begin
        #(20 * 2000);
        n_errors++;
        tally_and_finish();
    end
endmodule : ethernet_status_led_driver_tb
